// file: sfr_pkg.sv
package sfr_pkg;

  // Register offsets (9-bit data memory addresses)
  localparam logic [8:0] OFF_INDIRECT_B2 = 9'h100;
  localparam logic [8:0] OFF_TIMER_ZERO = 9'h101;
  localparam logic [8:0] OFF_PC_LOW_B2 = 9'h102;
  localparam logic [8:0] OFF_STATUS_B2 = 9'h103;
  localparam logic [8:0] OFF_POINTER_B2 = 9'h104;
  localparam logic [8:0] OFF_PORT_B = 9'h106;
  localparam logic [8:0] OFF_PC_UPPER_B2 = 9'h10A;
  localparam logic [8:0] OFF_IRQ_CTRL_B2 = 9'h10B;
  localparam logic [8:0] OFF_NVM_DATA_LO = 9'h10C;
  localparam logic [8:0] OFF_NVM_ADDR_LO = 9'h10D;
  localparam logic [8:0] OFF_NVM_DATA_HI = 9'h10E;
  localparam logic [8:0] OFF_NVM_ADDR_HI = 9'h10F;
  localparam logic [8:0] OFF_INDIRECT_B3 = 9'h180;
  localparam logic [8:0] OFF_OPTION = 9'h181;
  localparam logic [8:0] OFF_PC_LOW_B3 = 9'h182;
  localparam logic [8:0] OFF_STATUS_B3 = 9'h183;
  localparam logic [8:0] OFF_POINTER_B3 = 9'h184;
  localparam logic [8:0] OFF_PORT_B_DIR = 9'h186;
  localparam logic [8:0] OFF_PC_UPPER_B3 = 9'h18A;
  localparam logic [8:0] OFF_IRQ_CTRL_B3 = 9'h18B;
  localparam logic [8:0] OFF_NVM_CTRL_ONE = 9'h18C;
  localparam logic [8:0] OFF_NVM_UNLOCK = 9'h18D;
  localparam logic [8:0] OFF_RSVD_18E = 9'h18E;
  localparam logic [8:0] OFF_RSVD_18F = 9'h18F;
  // Own registers: event status and mask
  localparam logic [8:0] OFF_EVT_STATUS = 9'h190;
  localparam logic [8:0] OFF_EVT_MASK = 9'h191;
  // Port A direction, lower bank view
  localparam logic [8:0] OFF_PORT_A_DIR = 9'h085;

  // Field positions
  localparam int STATUS_IRP = 7;
  localparam int STATUS_BANK_HI = 6;
  localparam int STATUS_BANK_LO = 5;
  localparam int STATUS_TIMEOUT = 4;
  localparam int STATUS_PWRDOWN = 3;
  localparam int PORTA_BIT5 = 5;
  localparam int IRQ_GLOBAL_EN = 7;
  localparam int IRQ_PERIPH_EN = 6;
  localparam int IRQ_TIMER_EN = 5;
  localparam int IRQ_EXT_EN = 4;
  localparam int IRQ_PORT_EN = 3;
  localparam int IRQ_TIMER_FLAG = 2;
  localparam int IRQ_EXT_FLAG = 1;
  localparam int IRQ_PORT_FLAG = 0;

  // Field masks
  localparam logic [7:0] PC_UPPER_MASK = 8'h1F;
  localparam logic [7:0] NVM_DATA_HI_MASK = 8'h3F;
  localparam logic [7:0] NVM_ADDR_HI_MASK = 8'h07;
  localparam logic [7:0] NVM_CTRL_MASK = 8'h9F;
  localparam logic [7:0] STATUS_WR_MASK = 8'hE7;
  localparam logic [7:0] IRQ_FLAG_MASK = 8'h07;

  // Reset values
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_ONES = 8'hFF;
  localparam logic [7:0] RST_STATUS = 8'h18;
  localparam logic [7:0] RST_IRQ_CTRL = 8'h00;

  localparam int BANK_BYTES = 128;

endpackage : sfr_pkg

// file: pc_upper_transfer.sv
`timescale 1ns/1ps
`default_nettype none
// Program counter upper part, loaded only from the holding register
module pc_upper_transfer
  import sfr_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic [4:0] holding_in,
  input wire logic load_in,
  output logic [4:0] pc_upper_out
);

  typedef struct packed {
    logic [4:0] pc_upper_reg;
  } pcu_state_t;

  pcu_state_t st_reg;
  pcu_state_t st_next;

  // Transfer on upper update only
  always_comb begin
    st_next = st_reg;
    if (load_in) begin
      st_next.pc_upper_reg = holding_in;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign pc_upper_out = st_reg.pc_upper_reg;

endmodule : pc_upper_transfer
`default_nettype wire

// file: event_irq.sv
`timescale 1ns/1ps
`default_nettype none
// Sticky event bits, write-one-to-clear, masked onto one level
module event_irq
  import sfr_pkg::*;
#(
  parameter int WIDTH = 3
) (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic [WIDTH-1:0] event_in,
  input wire logic [WIDTH-1:0] clear_in,
  input wire logic mask_wr_in,
  input wire logic [WIDTH-1:0] mask_in,
  output logic [WIDTH-1:0] status_out,
  output logic [WIDTH-1:0] mask_out,
  output logic irq_out
);

  typedef struct packed {
    logic [WIDTH-1:0] status_reg;
    logic [WIDTH-1:0] mask_reg;
    logic irq_reg;
  } evt_state_t;

  evt_state_t st_reg;
  evt_state_t st_next;

  // Set wins over clear
  always_comb begin
    st_next = st_reg;
    st_next.status_reg = (st_reg.status_reg & ~clear_in) | event_in;
    if (mask_wr_in) begin
      st_next.mask_reg = mask_in;
    end
    st_next.irq_reg = |(st_next.status_reg & st_next.mask_reg);
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign status_out = st_reg.status_reg;
  assign mask_out = st_reg.mask_reg;
  assign irq_out = st_reg.irq_reg;

endmodule : event_irq
`default_nettype wire

// file: sfr_map_upper_banks.sv
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Five-bit holding register copied to counter upper part on upper update
// - Counter upper byte has no direct software path; changes by transfer
// - Core registers reach the same storage from every bank
// - Unimplemented locations and bits read zero; writes do nothing
// - Port A bit-5 direction ignores writes and always reads one
// - Second nvm control location reads zero; write target only, latched onto the unlock data output
// - Interrupt control bit order fixed; bits 7..1 reset to zero
// - Two status bits select one of four 128-byte banks
module sfr_map_upper_banks
  import sfr_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic [6:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic pc_upper_update_in,
  input wire logic [7:0] port_b_pins_in,
  input wire logic [7:0] timer_zero_in,
  input wire logic timer_zero_load_in,
  input wire logic timer_overflow_in,
  input wire logic ext_pin_event_in,
  input wire logic port_change_in,
  input wire logic [7:0] indirect_rdata_in,
  output logic [7:0] rdata_out,
  output logic [8:0] indirect_addr_out,
  output logic indirect_wr_out,
  output logic indirect_rd_out,
  output logic [7:0] indirect_wdata_out,
  output logic [4:0] pc_upper_out,
  output logic [7:0] pc_low_out,
  output logic [7:0] status_out,
  output logic [7:0] option_out,
  output logic [7:0] port_b_latch_out,
  output logic [7:0] port_b_dir_out,
  output logic [7:0] irq_control_out,
  output logic nvm_unlock_wr_out,
  output logic [7:0] nvm_unlock_data_out,
  output logic [7:0] nvm_ctrl_out,
  output logic irq_out
);

  typedef struct packed {
    logic [7:0] rdata_reg;
    logic [8:0] ind_addr_reg;
    logic ind_wr_reg;
    logic ind_rd_reg;
    logic ind_pend_reg;
    logic [7:0] ind_wdata_reg;
    logic [7:0] pc_low_reg;
    logic [7:0] pc_upper_hold_reg;
    logic [7:0] status_reg;
    logic [7:0] pointer_reg;
    logic [7:0] timer_reg;
    logic [7:0] port_b_latch_reg;
    logic [7:0] port_b_dir_reg;
    logic [7:0] option_reg;
    logic [7:0] irq_ctrl_reg;
    logic [7:0] nvm_data_lo_reg;
    logic [7:0] nvm_addr_lo_reg;
    logic [7:0] nvm_data_hi_reg;
    logic [7:0] nvm_addr_hi_reg;
    logic [7:0] nvm_ctrl_reg;
    logic unlock_wr_reg;
    logic [7:0] unlock_data_reg;
  } map_state_t;

  map_state_t st_reg;
  map_state_t st_next;
  logic [2:0] evt_status;
  logic [2:0] evt_mask;
  logic evt_irq;
  logic [2:0] evt_clear;
  logic evt_mask_wr;
  logic pc_upper_load;
  logic [8:0] full_addr;

  // Bank from status bits joined to 7-bit offset
  function automatic logic [8:0] bank_addr(input logic [7:0] status, input logic [6:0] off);
    bank_addr = {status[STATUS_BANK_HI], status[STATUS_BANK_LO], off};
  endfunction : bank_addr

  // Core register test: mirrored in every bank
  function automatic logic is_core(input logic [8:0] a, input logic [6:0] off);
    is_core = (a[6:0] == off);
  endfunction : is_core

  assign full_addr = bank_addr(st_reg.status_reg, addr_in);
  assign evt_clear = (wr_in && full_addr == OFF_EVT_STATUS) ? wdata_in[2:0] : 3'h0;
  assign evt_mask_wr = wr_in && (full_addr == OFF_EVT_MASK);
  assign pc_upper_load = pc_upper_update_in;

  // upper byte only loaded from holding register
  pc_upper_transfer u_pc_upper (
    .ref_clk_in(ref_clk_in),
    .sys_rst_in(sys_rst_in),
    .holding_in(st_reg.pc_upper_hold_reg[4:0]),
    .load_in(pc_upper_load),
    .pc_upper_out(pc_upper_out)
  );

  event_irq #(
    .WIDTH(3)
  ) u_evt (
    .ref_clk_in(ref_clk_in),
    .sys_rst_in(sys_rst_in),
    .event_in({timer_overflow_in, ext_pin_event_in, port_change_in}),
    .clear_in(evt_clear),
    .mask_wr_in(evt_mask_wr),
    .mask_in(wdata_in[2:0]),
    .status_out(evt_status),
    .mask_out(evt_mask),
    .irq_out(evt_irq)
  );

  // Register write, read and indirect forwarding
  always_comb begin
    st_next = st_reg;
    st_next.rdata_reg = RST_ZERO;
    st_next.ind_wr_reg = 1'b0;
    st_next.ind_rd_reg = 1'b0;
    st_next.unlock_wr_reg = 1'b0;
    if (timer_zero_load_in) begin
      st_next.timer_reg = timer_zero_in;
    end
    st_next.irq_ctrl_reg[IRQ_TIMER_FLAG] = st_reg.irq_ctrl_reg[IRQ_TIMER_FLAG] | timer_overflow_in;
    st_next.irq_ctrl_reg[IRQ_EXT_FLAG] = st_reg.irq_ctrl_reg[IRQ_EXT_FLAG] | ext_pin_event_in;
    st_next.irq_ctrl_reg[IRQ_PORT_FLAG] = st_reg.irq_ctrl_reg[IRQ_PORT_FLAG] | port_change_in;
    // Indirect read data returned one cycle after forwarding
    if (st_reg.ind_pend_reg) begin
      st_next.rdata_reg = indirect_rdata_in;
    end
    st_next.ind_pend_reg = 1'b0;
    if (wr_in) begin
      if (is_core(full_addr, OFF_INDIRECT_B2[6:0])) begin
        st_next.ind_wr_reg = 1'b1;
        st_next.ind_addr_reg = {st_reg.status_reg[STATUS_IRP], st_reg.pointer_reg};
        st_next.ind_wdata_reg = wdata_in;
      end else if (is_core(full_addr, OFF_PC_LOW_B2[6:0])) begin
        st_next.pc_low_reg = wdata_in;
      end else if (is_core(full_addr, OFF_STATUS_B2[6:0])) begin
        st_next.status_reg = (st_reg.status_reg & ~STATUS_WR_MASK) | (wdata_in & STATUS_WR_MASK);
      end else if (is_core(full_addr, OFF_POINTER_B2[6:0])) begin
        st_next.pointer_reg = wdata_in;
      end else if (is_core(full_addr, OFF_PC_UPPER_B2[6:0])) begin
        st_next.pc_upper_hold_reg = wdata_in & PC_UPPER_MASK;
      end else if (is_core(full_addr, OFF_IRQ_CTRL_B2[6:0])) begin
        st_next.irq_ctrl_reg = wdata_in | (st_next.irq_ctrl_reg & ~IRQ_FLAG_MASK & 8'h00)
          | (wdata_in & 8'h00);
        st_next.irq_ctrl_reg[IRQ_TIMER_FLAG] = wdata_in[IRQ_TIMER_FLAG] | timer_overflow_in;
        st_next.irq_ctrl_reg[IRQ_EXT_FLAG] = wdata_in[IRQ_EXT_FLAG] | ext_pin_event_in;
        st_next.irq_ctrl_reg[IRQ_PORT_FLAG] = wdata_in[IRQ_PORT_FLAG] | port_change_in;
      end else if (full_addr == OFF_TIMER_ZERO) begin
        st_next.timer_reg = wdata_in;
      end else if (full_addr == OFF_PORT_B) begin
        st_next.port_b_latch_reg = wdata_in;
      end else if (full_addr == OFF_NVM_DATA_LO) begin
        st_next.nvm_data_lo_reg = wdata_in;
      end else if (full_addr == OFF_NVM_ADDR_LO) begin
        st_next.nvm_addr_lo_reg = wdata_in;
      end else if (full_addr == OFF_NVM_DATA_HI) begin
        st_next.nvm_data_hi_reg = wdata_in & NVM_DATA_HI_MASK;
      end else if (full_addr == OFF_NVM_ADDR_HI) begin
        st_next.nvm_addr_hi_reg = wdata_in & NVM_ADDR_HI_MASK;
      end else if (full_addr == OFF_OPTION) begin
        st_next.option_reg = wdata_in;
      end else if (full_addr == OFF_PORT_B_DIR) begin
        st_next.port_b_dir_reg = wdata_in;
      end else if (full_addr == OFF_NVM_CTRL_ONE) begin
        st_next.nvm_ctrl_reg = wdata_in & NVM_CTRL_MASK;
      end else if (full_addr == OFF_NVM_UNLOCK) begin
        st_next.unlock_wr_reg = 1'b1;
        st_next.unlock_data_reg = wdata_in;
      end
    end else if (rd_in) begin
      if (is_core(full_addr, OFF_INDIRECT_B2[6:0])) begin
        st_next.ind_rd_reg = 1'b1;
        st_next.ind_pend_reg = 1'b1;
        st_next.ind_addr_reg = {st_reg.status_reg[STATUS_IRP], st_reg.pointer_reg};
      end else if (is_core(full_addr, OFF_PC_LOW_B2[6:0])) begin
        st_next.rdata_reg = st_reg.pc_low_reg;
      end else if (is_core(full_addr, OFF_STATUS_B2[6:0])) begin
        st_next.rdata_reg = st_reg.status_reg;
      end else if (is_core(full_addr, OFF_POINTER_B2[6:0])) begin
        st_next.rdata_reg = st_reg.pointer_reg;
      end else if (is_core(full_addr, OFF_PC_UPPER_B2[6:0])) begin
        st_next.rdata_reg = st_reg.pc_upper_hold_reg;
      end else if (is_core(full_addr, OFF_IRQ_CTRL_B2[6:0])) begin
        st_next.rdata_reg = st_reg.irq_ctrl_reg;
      end else if (full_addr == OFF_PORT_A_DIR) begin
        st_next.rdata_reg = 8'h00;
        st_next.rdata_reg[PORTA_BIT5] = 1'b1;
      end else if (full_addr == OFF_TIMER_ZERO) begin
        st_next.rdata_reg = st_reg.timer_reg;
      end else if (full_addr == OFF_PORT_B) begin
        st_next.rdata_reg = port_b_pins_in;
      end else if (full_addr == OFF_NVM_DATA_LO) begin
        st_next.rdata_reg = st_reg.nvm_data_lo_reg;
      end else if (full_addr == OFF_NVM_ADDR_LO) begin
        st_next.rdata_reg = st_reg.nvm_addr_lo_reg;
      end else if (full_addr == OFF_NVM_DATA_HI) begin
        st_next.rdata_reg = st_reg.nvm_data_hi_reg;
      end else if (full_addr == OFF_NVM_ADDR_HI) begin
        st_next.rdata_reg = st_reg.nvm_addr_hi_reg;
      end else if (full_addr == OFF_OPTION) begin
        st_next.rdata_reg = st_reg.option_reg;
      end else if (full_addr == OFF_PORT_B_DIR) begin
        st_next.rdata_reg = st_reg.port_b_dir_reg;
      end else if (full_addr == OFF_NVM_CTRL_ONE) begin
        st_next.rdata_reg = st_reg.nvm_ctrl_reg;
      end else if (full_addr == OFF_EVT_STATUS) begin
        st_next.rdata_reg = {5'h00, evt_status};
      end else if (full_addr == OFF_EVT_MASK) begin
        st_next.rdata_reg = {5'h00, evt_mask};
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      st_reg <= '0;
      st_reg.status_reg <= RST_STATUS;
      st_reg.port_b_dir_reg <= RST_ONES;
      st_reg.option_reg <= RST_ONES;
      st_reg.irq_ctrl_reg <= RST_IRQ_CTRL;
    end else begin
      st_reg <= st_next;
    end
  end

  // Register-driven outputs
  assign rdata_out = st_reg.rdata_reg;
  assign indirect_addr_out = st_reg.ind_addr_reg;
  assign indirect_wr_out = st_reg.ind_wr_reg;
  assign indirect_rd_out = st_reg.ind_rd_reg;
  assign indirect_wdata_out = st_reg.ind_wdata_reg;
  assign pc_low_out = st_reg.pc_low_reg;
  assign status_out = st_reg.status_reg;
  assign option_out = st_reg.option_reg;
  assign port_b_latch_out = st_reg.port_b_latch_reg;
  assign port_b_dir_out = st_reg.port_b_dir_reg;
  assign irq_control_out = st_reg.irq_ctrl_reg;
  assign nvm_unlock_wr_out = st_reg.unlock_wr_reg;
  assign nvm_unlock_data_out = st_reg.unlock_data_reg;
  assign nvm_ctrl_out = st_reg.nvm_ctrl_reg;
  assign irq_out = evt_irq;

  property p_pc_transfer;
    @(posedge ref_clk_in) disable iff (sys_rst_in)
      pc_upper_update_in |=> (pc_upper_out == $past(st_reg.pc_upper_hold_reg[4:0]));
  endproperty
  a_pc_transfer: assert property (p_pc_transfer)
    else $error("counter upper not loaded from holding register");

  property p_pc_stable;
    @(posedge ref_clk_in) disable iff (sys_rst_in)
      !pc_upper_update_in |=> $stable(pc_upper_out);
  endproperty
  a_pc_stable: assert property (p_pc_stable)
    else $error("counter upper changed without transfer");

  // mirrored pointer write from any bank
  property p_mirror;
    @(posedge ref_clk_in) disable iff (sys_rst_in)
      (wr_in && addr_in == OFF_POINTER_B2[6:0]) |=> (st_reg.pointer_reg == $past(wdata_in));
  endproperty
  a_mirror: assert property (p_mirror)
    else $error("pointer not reached from current bank");

  property p_unmapped_zero;
    @(posedge ref_clk_in) disable iff (sys_rst_in)
      (rd_in && full_addr == OFF_RSVD_18E) |=> (rdata_out == 8'h00);
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero)
    else $error("reserved location read nonzero");

  property p_porta_bit5;
    @(posedge ref_clk_in) disable iff (sys_rst_in)
      (rd_in && full_addr == OFF_PORT_A_DIR) |=> rdata_out[PORTA_BIT5];
  endproperty
  a_porta_bit5: assert property (p_porta_bit5)
    else $error("port A bit-5 direction read as zero");

  // unlock write strobes for one cycle, then the strobe drops
  property p_unlock;
    @(posedge ref_clk_in) disable iff (sys_rst_in)
      (wr_in && full_addr == OFF_NVM_UNLOCK) |=> nvm_unlock_wr_out ##1 !nvm_unlock_wr_out;
  endproperty
  a_unlock: assert property (p_unlock)
    else $error("unlock strobe wrong");

  property p_timer_flag;
    @(posedge ref_clk_in) disable iff (sys_rst_in)
      timer_overflow_in |=> irq_control_out[IRQ_TIMER_FLAG];
  endproperty
  a_timer_flag: assert property (p_timer_flag)
    else $error("timer flag not set");

  property p_indirect;
    @(posedge ref_clk_in) disable iff (sys_rst_in)
      (rd_in && addr_in == OFF_INDIRECT_B2[6:0])
        |=> indirect_rd_out && indirect_addr_out[7:0] == $past(st_reg.pointer_reg);
  endproperty
  a_indirect: assert property (p_indirect)
    else $error("indirect access not via pointer");

  // bank bits follow a status write
  property p_bank_write;
    @(posedge ref_clk_in) disable iff (sys_rst_in)
      (wr_in && is_core(full_addr, OFF_STATUS_B2[6:0]))
        |=> (status_out[STATUS_BANK_HI:STATUS_BANK_LO] == $past(wdata_in[6:5]));
  endproperty
  a_bank_write: assert property (p_bank_write)
    else $error("bank select bits not taken from status write");

  // holding register upper bits read zero
  property p_hold_upper_zero;
    @(posedge ref_clk_in) disable iff (sys_rst_in)
      (rd_in && is_core(full_addr, OFF_PC_UPPER_B2[6:0])) |=> (rdata_out[7:5] == 3'h0);
  endproperty
  a_hold_upper_zero: assert property (p_hold_upper_zero)
    else $error("holding register upper bits read nonzero");

  property p_unlock_read;
    @(posedge ref_clk_in) disable iff (sys_rst_in)
      (rd_in && full_addr == OFF_NVM_UNLOCK) |=> (rdata_out == 8'h00);
  endproperty
  a_unlock_read: assert property (p_unlock_read)
    else $error("unlock location read nonzero");

endmodule : sfr_map_upper_banks
`default_nettype wire

// file: tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import sfr_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [6:0] addr = 7'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic upd = 1'b0;
  logic [7:0] pins = 8'h96;
  logic [7:0] tmr = 8'h33;
  logic tmr_ld = 1'b0;
  logic t_ovf = 1'b0;
  logic ext_ev = 1'b0;
  logic pchg = 1'b0;
  logic [7:0] ind_rdata = 8'hC3;
  logic [7:0] rdata, ind_wdata, pc_lo, status, option, pb_lat, pb_dir, irqc, unl_data, nvm_ctrl;
  logic [8:0] ind_addr;
  logic [4:0] pc_up;
  logic ind_wr, ind_rd, unl_wr, irq;
  int errors = 0;
  int samples_checked = 0;
  logic [7:0] exp_irqc;
  logic [6:0] unused_locs [6] = '{7'h05, 7'h07, 7'h08, 7'h09, 7'h0E, 7'h0F};

  sfr_map_upper_banks uut (
    .ref_clk_in(clk), .sys_rst_in(rst), .addr_in(addr), .wdata_in(wdata), .wr_in(wr),
    .rd_in(rd), .pc_upper_update_in(upd), .port_b_pins_in(pins), .timer_zero_in(tmr),
    .timer_zero_load_in(tmr_ld), .timer_overflow_in(t_ovf), .ext_pin_event_in(ext_ev),
    .port_change_in(pchg), .indirect_rdata_in(ind_rdata), .rdata_out(rdata),
    .indirect_addr_out(ind_addr), .indirect_wr_out(ind_wr), .indirect_rd_out(ind_rd),
    .indirect_wdata_out(ind_wdata), .pc_upper_out(pc_up), .pc_low_out(pc_lo),
    .status_out(status), .option_out(option), .port_b_latch_out(pb_lat),
    .port_b_dir_out(pb_dir), .irq_control_out(irqc), .nvm_unlock_wr_out(unl_wr),
    .nvm_unlock_data_out(unl_data), .nvm_ctrl_out(nvm_ctrl), .irq_out(irq)
  );

  // Clock, 8 ns period
  always #4 clk = ~clk;

  // Compare and count
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One-cycle write strobe
  task automatic wr_reg(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask : wr_reg

  // One-cycle read strobe, data checked in the following cycle
  task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    check(rdata, exp);
  endtask : rd_chk

  // Bank and indirect bank selection through status
  task automatic set_bank(input logic irp, input logic [1:0] b);
    wr_reg(OFF_STATUS_B2[6:0], {irp, b, 5'h00});
  endtask : set_bank

  // One-cycle pulse on update, event and load inputs
  task automatic pulse(input logic [4:0] sel);
    @(posedge clk);
    {upd, t_ovf, ext_ev, pchg, tmr_ld} <= sel;
    @(posedge clk);
    {upd, t_ovf, ext_ev, pchg, tmr_ld} <= 5'h00;
    #1;
  endtask : pulse

  // Verdict and end of run
  task automatic tally_and_finish();
    $display("errors %0d, samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : tally_and_finish

  // Hang guard
  initial begin
    repeat (5000) @(posedge clk);
    errors++;
    tally_and_finish();
  end

  // Main sequence
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    #1;
    check(irqc & 8'hFE, 8'h00);
    check(option, 8'hFF);
    check(pb_dir, 8'hFF);
    check({3'h0, pc_up}, 8'h00);
    rd_chk(OFF_STATUS_B2[6:0], 8'h18);
    set_bank(1'b0, 2'b11);
    rd_chk(OFF_STATUS_B3[6:0], 8'h78);
    rd_chk(OFF_OPTION[6:0], 8'hFF);
    wr_reg(OFF_PORT_B_DIR[6:0], 8'h0F);
    check(pb_dir, 8'h0F);
    wr_reg(OFF_POINTER_B3[6:0], 8'h40);
    wr_reg(OFF_PC_UPPER_B3[6:0], 8'hFF);
    rd_chk(OFF_PC_UPPER_B3[6:0], 8'h1F);
    check({3'h0, pc_up}, 8'h00);
    pulse(5'b10000);
    check({3'h0, pc_up}, 8'h1F);
    wr_reg(OFF_PC_UPPER_B3[6:0], 8'h0A);
    check({3'h0, pc_up}, 8'h1F);
    foreach (unused_locs[i]) wr_reg(unused_locs[i], 8'hFF);
    foreach (unused_locs[i]) rd_chk(unused_locs[i], 8'h00);
    wr_reg(OFF_NVM_UNLOCK[6:0], 8'h5A);
    check({7'h00, unl_wr}, 8'h01);
    check(unl_data, 8'h5A);
    @(posedge clk);
    #1;
    check({7'h00, unl_wr}, 8'h00);
    rd_chk(OFF_NVM_UNLOCK[6:0], 8'h00);
    // same storage seen from bank 2
    wr_reg(OFF_IRQ_CTRL_B3[6:0], 8'hF8);
    set_bank(1'b1, 2'b10);
    rd_chk(OFF_IRQ_CTRL_B2[6:0], 8'hF8);
    rd_chk(OFF_POINTER_B2[6:0], 8'h40);
    rd_chk(OFF_PC_UPPER_B2[6:0], 8'h0A);
    wr_reg(OFF_PC_LOW_B2[6:0], 8'hA5);
    check(pc_lo, 8'hA5);
    check(status, 8'hD8);
    // flags set by events in documented order
    exp_irqc = 8'hF8;
    for (int i = 0; i < 3; i++) begin
      pulse(5'b01000 >> i);
      @(posedge clk);
      #1;
      exp_irqc = exp_irqc | (8'h04 >> i);
      check(irqc, exp_irqc);
    end
    // bank 2 port data and timer
    rd_chk(OFF_PORT_B[6:0], 8'h96);
    wr_reg(OFF_PORT_B[6:0], 8'h3C);
    check(pb_lat, 8'h3C);
    pulse(5'b00001);
    rd_chk(OFF_TIMER_ZERO[6:0], 8'h33);
    // nvm high bytes keep only implemented bits
    wr_reg(OFF_NVM_ADDR_LO[6:0], 8'h5A);
    rd_chk(OFF_NVM_ADDR_LO[6:0], 8'h5A);
    wr_reg(OFF_NVM_DATA_HI[6:0], 8'hFF);
    rd_chk(OFF_NVM_DATA_HI[6:0], 8'h3F);
    wr_reg(OFF_NVM_ADDR_HI[6:0], 8'hFF);
    rd_chk(OFF_NVM_ADDR_HI[6:0], 8'h07);
    // indirect write and read via pointer
    wr_reg(OFF_INDIRECT_B2[6:0], 8'h77);
    check({7'h00, ind_wr}, 8'h01);
    check(ind_addr[7:0], 8'h40);
    check({7'h00, ind_addr[8]}, 8'h01);
    check(ind_wdata, 8'h77);
    @(posedge clk);
    addr <= OFF_INDIRECT_B2[6:0];
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    check({7'h00, ind_rd}, 8'h01);
    @(posedge clk);
    #1;
    check(rdata, 8'hC3);
    // Event status, mask and level interrupt
    set_bank(1'b0, 2'b11);
    rd_chk(OFF_EVT_STATUS[6:0], 8'h07);
    check({7'h00, irq}, 8'h00);
    wr_reg(OFF_EVT_MASK[6:0], 8'h02);
    repeat (2) @(posedge clk);
    #1;
    check({7'h00, irq}, 8'h01);
    wr_reg(OFF_EVT_STATUS[6:0], 8'h02);
    repeat (2) @(posedge clk);
    #1;
    check({7'h00, irq}, 8'h00);
    rd_chk(OFF_EVT_STATUS[6:0], 8'h05);
    wr_reg(OFF_EVT_STATUS[6:0], 8'h05);
    rd_chk(OFF_EVT_STATUS[6:0], 8'h00);
    // counter low byte seen from bank 3, nvm control bits
    rd_chk(OFF_PC_LOW_B3[6:0], 8'hA5);
    wr_reg(OFF_NVM_CTRL_ONE[6:0], 8'hFF);
    check(nvm_ctrl, 8'h9F);
    rd_chk(OFF_NVM_CTRL_ONE[6:0], 8'h9F);
    set_bank(1'b0, 2'b01);
    wr_reg(OFF_PORT_A_DIR[6:0], 8'h00);
    rd_chk(OFF_PORT_A_DIR[6:0], 8'h20);
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
